// >>> src/rfm_defs.vh
// constants for the redundancy fault manager
`ifndef RFM_DEFS_VH
`define RFM_DEFS_VH
// register byte offsets
`define RFM_CTRL_OFS      5'h00
`define RFM_STATUS_OFS    5'h04
`define RFM_MASK_LO_OFS   5'h08
`define RFM_MASK_HI_OFS   5'h0C
`define RFM_WDOG_OFS      5'h10
`define RFM_CFG_OFS       5'h14
// control register fields
`define RFM_CTRL_MAGIC1_LSB 0
`define RFM_CTRL_MAGIC2_LSB 8
`define RFM_CTRL_RECOV_BIT  16
`define RFM_CTRL_SMRST_BIT  17
`define RFM_CTRL_TEST_BIT   24
// status register fields
`define RFM_ST_FATAL_BIT    0
`define RFM_ST_ILLEGAL_BIT  1
`define RFM_ST_UE_BIT       2
`define RFM_ST_WDOG_BIT     3
`define RFM_ST_MISCMP_BIT   4
`define RFM_ST_STATE_LSB    8
// reset values and defaults
`define RFM_MASK_RESET      64'hFFFFFFFFFFFFFFFF
`define RFM_MAGIC1_DEF      8'h00
`define RFM_MAGIC2_DEF      8'h00
`define RFM_WDOG_WIDTH_DEF  30
`endif

// >>> src/rfm_manager.v
// redundancy fault manager top with avalon-mm register slave
//
// Local design decisions: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
`include "rfm_defs.vh"
module rfm_manager #(
    parameter       NUM_CMP         = 1,
    parameter       LOCKSTEP        = 0,
    parameter       ILLEGAL_FATAL   = 1,
    parameter       USE_TMR_DISABLE = 1,
    parameter       USE_DBG_DISABLE = 1,
    parameter       UE_FATAL        = 1,
    parameter       USE_MASK        = 1,
    parameter       WDOG_EXTERNAL   = 0,
    parameter       WDOG_WIDTH      = `RFM_WDOG_WIDTH_DEF,
    parameter [7:0] MAGIC1          = `RFM_MAGIC1_DEF,
    parameter [7:0] MAGIC2          = `RFM_MAGIC2_DEF,
    parameter [63:0] MASK_RESET     = `RFM_MASK_RESET
) (
    input  wire                 clock_i,
    input  wire                 rst_i,
    input  wire [4:0]           avs_address_i,
    input  wire                 avs_read_i,
    input  wire                 avs_write_i,
    input  wire [31:0]          avs_writedata_i,
    input  wire [3:0]           avs_byteenable_i,
    output reg  [31:0]          avs_readdata_o,
    output wire                 avs_waitrequest_o,
    input  wire [3*NUM_CMP-1:0] miscompare_i,
    input  wire                 tmr_disable_i,
    input  wire                 debug_disable_i,
    input  wire                 bus_uncorrectable_error_in_i,
    input  wire                 watchdog_expired_i,
    output wire                 fatal_reset_o,
    output wire                 recover_reset_o,
    output wire                 test_mode_o,
    output wire                 lockstep_break_o,
    output wire [1:0]           state_o
);
    // ==========================================
    // states
    localparam [1:0] ST_RUN     = 2'b00;
    localparam [1:0] ST_RECOVER = 2'b01;
    localparam [1:0] ST_BREAK   = 2'b10;
    localparam [1:0] ST_FATAL   = 2'b11;

    // ==========================================
    // declarations
    reg  [3*NUM_CMP-1:0] cmp_s1_reg;
    reg  [3*NUM_CMP-1:0] cmp_s2_reg;
    reg  [1:0]           tmrd_s_reg;
    reg  [1:0]           dbgd_s_reg;
    reg  [1:0]           ue_s_reg;
    reg  [63:0]          mask_reg;
    reg                  test_reg;
    reg                  recov_req_reg;
    reg                  smrst_req_reg;
    reg  [1:0]           state_reg;
    reg  [1:0]           state_next;
    reg                  fatal_st_reg;
    reg                  illegal_st_reg;
    reg                  ue_st_reg;
    reg                  wdog_st_reg;
    reg                  miscmp_st_reg;
    reg                  ack_reg;
    reg                  illegal_any;
    reg                  legal_any;
    reg  [NUM_CMP-1:0]   cmp_active;
    integer              k;
    wire                 tmr_off;
    wire                 dbg_off;
    wire                 ue_hit;
    wire                 wdog_exp;
    wire                 fatal_cond;
    wire                 wr_hit;
    wire                 ctrl_wr;
    wire                 wdog_kick;
    wire [7:0]           st_byte;

    // ==========================================
    // helper: one-hot check for a comparator group
    function illegal_of;
        input [2:0] m;
        begin
            illegal_of = (m == 3'b001) || (m == 3'b010) || (m == 3'b100);
        end
    endfunction

    // ==========================================
    // input synchronisers
    always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            cmp_s1_reg <= {(3*NUM_CMP){1'b0}};
            cmp_s2_reg <= {(3*NUM_CMP){1'b0}};
            tmrd_s_reg <= 2'h0;
            dbgd_s_reg <= 2'h0;
            ue_s_reg   <= 2'h0;
        end else begin
            cmp_s1_reg <= miscompare_i;
            cmp_s2_reg <= cmp_s1_reg;
            tmrd_s_reg <= {tmrd_s_reg[0], tmr_disable_i};
            dbgd_s_reg <= {dbgd_s_reg[0], debug_disable_i};
            ue_s_reg   <= {ue_s_reg[0], bus_uncorrectable_error_in_i};
        end
    end

    assign tmr_off = (USE_TMR_DISABLE != 0) && tmrd_s_reg[1];
    assign dbg_off = (USE_DBG_DISABLE != 0) && dbgd_s_reg[1];
    assign ue_hit  = (UE_FATAL != 0) && ue_s_reg[1];

    // ==========================================
    // comparator evaluation
    always @* begin
        illegal_any = 1'b0;
        legal_any   = 1'b0;
        for (k = 0; k < NUM_CMP; k = k + 1) begin
            cmp_active[k] = (USE_MASK == 0) || mask_reg[k] || !dbg_off;
            if (cmp_active[k] && !tmr_off && (LOCKSTEP == 0)) begin
                if (illegal_of(cmp_s2_reg[3*k +: 3])) begin
                    illegal_any = 1'b1;
                end else if (|cmp_s2_reg[3*k +: 3]) begin
                    legal_any = 1'b1;
                end
            end else if (cmp_active[k] && !tmr_off) begin
                if (cmp_s2_reg[3*k]) begin
                    legal_any = 1'b1;
                end
            end
        end
    end

    // ==========================================
    // watchdog
    assign wr_hit    = avs_write_i && ack_reg;
    assign wdog_kick = wr_hit && (avs_address_i == `RFM_WDOG_OFS);
    assign ctrl_wr   = wr_hit && (avs_address_i == `RFM_CTRL_OFS);

    rfm_watchdog #(
        .WIDTH    (WDOG_WIDTH),
        .EXTERNAL (WDOG_EXTERNAL)
    ) u_wdog (
        .clock_i       (clock_i),
        .rst_i         (rst_i),
        .kick_i        (wdog_kick),
        .ext_expired_i (watchdog_expired_i),
        .expired_o     (wdog_exp)
    );

    assign fatal_cond = wdog_exp
        || ue_hit
        || (illegal_any && (ILLEGAL_FATAL != 0));

    // ==========================================
    // redundancy state machine
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_RUN: begin
                if (fatal_cond) begin
                    state_next = ST_FATAL;
                end else if (legal_any && (LOCKSTEP != 0)) begin
                    state_next = ST_BREAK;
                end else if (legal_any || illegal_any) begin
                    state_next = ST_RECOVER;
                end
            end
            ST_RECOVER: begin
                if (fatal_cond) begin
                    state_next = ST_FATAL;
                end else if (recov_req_reg) begin
                    state_next = ST_RUN;
                end
            end
            ST_BREAK: begin
                if (fatal_cond) begin
                    state_next = ST_FATAL;
                end else if (recov_req_reg) begin
                    state_next = ST_RUN;
                end
            end
            ST_FATAL: begin
                if (smrst_req_reg && dbg_off) begin
                    state_next = ST_RUN;
                end
            end
            default: begin
                state_next = ST_RUN;
            end
        endcase
    end

    // ==========================================
    // registers and status
    always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg      <= ST_RUN;
            mask_reg       <= MASK_RESET;
            test_reg       <= 1'b0;
            recov_req_reg  <= 1'b0;
            smrst_req_reg  <= 1'b0;
            fatal_st_reg   <= 1'b0;
            illegal_st_reg <= 1'b0;
            ue_st_reg      <= 1'b0;
            wdog_st_reg    <= 1'b0;
            miscmp_st_reg  <= 1'b0;
        end else begin
            state_reg     <= state_next;
            recov_req_reg <= 1'b0;
            smrst_req_reg <= 1'b0;
            if (ctrl_wr && avs_byteenable_i[0] && avs_byteenable_i[2]
                && avs_writedata_i[`RFM_CTRL_MAGIC1_LSB +: 8] == MAGIC1) begin
                recov_req_reg <= avs_writedata_i[`RFM_CTRL_RECOV_BIT];
                smrst_req_reg <= avs_writedata_i[`RFM_CTRL_SMRST_BIT];
            end
            if (ctrl_wr && avs_byteenable_i[1] && avs_byteenable_i[3]
                && avs_writedata_i[`RFM_CTRL_MAGIC2_LSB +: 8] == MAGIC2) begin
                test_reg <= avs_writedata_i[`RFM_CTRL_TEST_BIT];
            end
            if (wr_hit && avs_address_i == `RFM_MASK_LO_OFS) begin
                mask_reg[31:0] <= avs_writedata_i;
            end
            if (wr_hit && avs_address_i == `RFM_MASK_HI_OFS) begin
                mask_reg[63:32] <= avs_writedata_i;
            end
            // write-one-to-clear; a new event wins over the clear
            if (wr_hit && avs_address_i == `RFM_STATUS_OFS) begin
                fatal_st_reg   <= fatal_st_reg & ~avs_writedata_i[`RFM_ST_FATAL_BIT];
                illegal_st_reg <= illegal_st_reg & ~avs_writedata_i[`RFM_ST_ILLEGAL_BIT];
                ue_st_reg      <= ue_st_reg & ~avs_writedata_i[`RFM_ST_UE_BIT];
                wdog_st_reg    <= wdog_st_reg & ~avs_writedata_i[`RFM_ST_WDOG_BIT];
                miscmp_st_reg  <= miscmp_st_reg & ~avs_writedata_i[`RFM_ST_MISCMP_BIT];
            end
            if (fatal_cond) begin
                fatal_st_reg <= 1'b1;
            end
            if (illegal_any) begin
                illegal_st_reg <= 1'b1;
            end
            if (ue_hit) begin
                ue_st_reg <= 1'b1;
            end
            if (wdog_exp) begin
                wdog_st_reg <= 1'b1;
            end
            if (legal_any) begin
                miscmp_st_reg <= 1'b1;
            end
        end
    end

    // ==========================================
    // outputs
    assign fatal_reset_o    = (state_reg == ST_FATAL) && !dbg_off;
    assign recover_reset_o  = (state_reg == ST_RECOVER) && recov_req_reg;
    assign lockstep_break_o = (state_reg == ST_BREAK);
    assign test_mode_o      = test_reg;
    assign state_o          = state_reg;

    // ==========================================
    // avalon-mm slave: one wait cycle per access
    always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= (avs_read_i || avs_write_i) && !ack_reg;
        end
    end
    assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_reg;

    assign st_byte = {3'h0, miscmp_st_reg, wdog_st_reg, ue_st_reg, illegal_st_reg, fatal_st_reg};

    always @* begin
        case (avs_address_i)
            `RFM_CTRL_OFS:    avs_readdata_o = {7'h00, test_reg, 24'h000000};
            `RFM_STATUS_OFS:  avs_readdata_o = {22'h000000, state_reg, st_byte};
            `RFM_MASK_LO_OFS: avs_readdata_o = mask_reg[31:0];
            `RFM_MASK_HI_OFS: avs_readdata_o = mask_reg[63:32];
            `RFM_CFG_OFS:     avs_readdata_o = {26'h0000000, dbg_off, tmr_off, 2'h0,
                                                LOCKSTEP != 0, WDOG_EXTERNAL != 0};
            default:          avs_readdata_o = 32'h00000000;
        endcase
    end
endmodule

// >>> src/rfm_watchdog.v
// software watchdog: internal counter or external expiry input
`timescale 1ns/1ps
`include "rfm_defs.vh"
module rfm_watchdog #(
    parameter WIDTH    = `RFM_WDOG_WIDTH_DEF,
    parameter EXTERNAL = 0
) (
    input  wire clock_i,
    input  wire rst_i,
    input  wire kick_i,
    input  wire ext_expired_i,
    output wire expired_o
);
    reg [WIDTH-1:0] count_reg;
    reg             exp_reg;
    reg             ext_s1_reg;
    reg             ext_s2_reg;
    // ==========================================
    // counter and external synchroniser
    always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            count_reg  <= {WIDTH{1'b0}};
            exp_reg    <= 1'b0;
            ext_s1_reg <= 1'b0;
            ext_s2_reg <= 1'b0;
        end else begin
            ext_s1_reg <= ext_expired_i;
            ext_s2_reg <= ext_s1_reg;
            if (kick_i) begin
                count_reg <= {WIDTH{1'b0}};
            end else if (EXTERNAL == 0 && !exp_reg) begin
                if (&count_reg) begin
                    exp_reg <= 1'b1;
                end
                count_reg <= count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
            end
            if (EXTERNAL != 0 && ext_s2_reg) begin
                exp_reg <= 1'b1;
            end
        end
    end
    assign expired_o = exp_reg;
endmodule

// >>> verif/rfm_cores_model.sv
// model of the redundant cores and their comparators
`timescale 1ns/1ps
module rfm_cores_model #(
    parameter NUM_CMP = 1
) (
    input  wire                 clock_i,
    input  wire                 rst_i,
    input  wire [1:0]           bad_core_i,
    input  wire [5:0]           bad_grp_i,
    input  wire                 cmp_fault_i,
    output reg  [3*NUM_CMP-1:0] miscompare_o
);
    reg [7:0] cnt_reg;
    reg [7:0] c1;
    reg [7:0] c2;
    reg [7:0] c3;
    integer   k;
    // ==========================================
    // three cores, pairwise compare per group
    always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_reg <= 8'h00;
            miscompare_o <= {3*NUM_CMP{1'b0}};
        end else begin
            cnt_reg <= cnt_reg + 8'h01;
            for (k = 0; k < NUM_CMP; k = k + 1) begin
                c1 = cnt_reg ^ {8{k == bad_grp_i && bad_core_i == 2'd1}};
                c2 = cnt_reg ^ {8{k == bad_grp_i && bad_core_i == 2'd2}};
                c3 = cnt_reg ^ {8{k == bad_grp_i && bad_core_i == 2'd3}};
                miscompare_o[3*k+:3] <= {c1 != c3, c2 != c3, c1 != c2};
                if (cmp_fault_i && k == bad_grp_i) begin
                    miscompare_o[3*k+:3] <= 3'h1;
                end
            end
        end
    end
endmodule

// >>> verif/rfm_manager_properties.sv
// assertion checker for the redundancy fault manager
`timescale 1ns/1ps
module rfm_manager_props #(
    parameter       NUM_CMP       = 1,
    parameter       ILLEGAL_FATAL = 1,
    parameter [7:0] MAGIC1        = 8'h00,
    parameter [7:0] MAGIC2        = 8'h00
) (
    input wire                 clock_i,
    input wire                 rst_i,
    input wire [4:0]           avs_address_i,
    input wire                 avs_read_i,
    input wire                 avs_write_i,
    input wire [31:0]          avs_writedata_i,
    input wire [31:0]          avs_readdata_o,
    input wire                 avs_waitrequest_o,
    input wire [3*NUM_CMP-1:0] miscompare_i,
    input wire                 tmr_disable_i,
    input wire                 debug_disable_i,
    input wire                 bus_uncorrectable_error_in_i,
    input wire                 watchdog_expired_i,
    input wire                 fatal_reset_o,
    input wire                 recover_reset_o,
    input wire                 test_mode_o,
    input wire [1:0]           state_o
);
    wire req    = avs_read_i | avs_write_i;
    wire acc    = avs_write_i && !avs_waitrequest_o && avs_address_i == 5'h00;
    wire rec_ok = acc && avs_writedata_i[7:0] == MAGIC1 && avs_writedata_i[16];
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    // ==========================================
    // properties
    a_wait_first: assert property ($rose(req) |-> avs_waitrequest_o)
        else $error("no wait on first cycle");
    a_wait_second: assert property (req && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("wait longer than one cycle");
    a_unmapped_read: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i > 5'h14
        |-> avs_readdata_o == 32'h0) else $error("unmapped read not zero");
    a_fatal_needs_state: assert property (fatal_reset_o |-> state_o == 2'd3)
        else $error("fatal reset outside fatal state");
    a_fatal_raised: assert property ((state_o == 2'd3 && !debug_disable_i)[*4] |-> fatal_reset_o)
        else $error("fatal reset missing");
    a_debug_blocks: assert property (debug_disable_i[*4] |-> !fatal_reset_o)
        else $error("fatal reset not blocked");
    a_ue_fatal: assert property (bus_uncorrectable_error_in_i[*3] |-> ##[0:3] state_o == 2'd3)
        else $error("bus error not fatal");
    a_wdog_fatal: assert property (watchdog_expired_i[*3] |-> ##[0:3] state_o == 2'd3)
        else $error("watchdog expiry not fatal");
    a_illegal_fatal: assert property ((ILLEGAL_FATAL != 0 && !debug_disable_i && !tmr_disable_i
        && $onehot(miscompare_i[2:0]))[*3] |-> ##[0:3] state_o == 2'd3) else $error("illegal not fatal");
    a_recover_magic: assert property (recover_reset_o |-> rec_ok || $past(rec_ok))
        else $error("recover pulse without magic");
    a_recover_pulse: assert property (recover_reset_o |=> !recover_reset_o)
        else $error("recover pulse too long");
    a_test_magic: assert property ($rose(test_mode_o) |-> $past(acc && avs_writedata_i[15:8] == MAGIC2
        && avs_writedata_i[24])) else $error("test mode without magic");
    c_fatal: cover property (fatal_reset_o);
    c_recover: cover property (recover_reset_o);
    c_test: cover property ($rose(test_mode_o));
endmodule
bind rfm_manager rfm_manager_props #(.NUM_CMP(NUM_CMP), .ILLEGAL_FATAL(ILLEGAL_FATAL), .MAGIC1(MAGIC1),
    .MAGIC2(MAGIC2)) rfm_manager_props_i (.clock_i(clock_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .miscompare_i(miscompare_i),
    .tmr_disable_i(tmr_disable_i), .debug_disable_i(debug_disable_i),
    .bus_uncorrectable_error_in_i(bus_uncorrectable_error_in_i), .watchdog_expired_i(watchdog_expired_i),
    .fatal_reset_o(fatal_reset_o), .recover_reset_o(recover_reset_o), .test_mode_o(test_mode_o),
    .state_o(state_o));

// >>> verif/rfm_manager_test.sv
// self-checking testbench of the redundancy fault manager
`timescale 1ns/1ps
module rfm_manager_test;
    localparam [7:0] M1 = 8'h5A;
    localparam [7:0] M2 = 8'hC3;
    reg clock_i = 1'b0;
    reg rst_i = 1'b1;
    reg [4:0] avs_address_i = 5'h00;
    reg avs_read_i = 1'b0;
    reg avs_write_i = 1'b0;
    reg [31:0] avs_writedata_i = 32'h0;
    reg tmr_disable_i = 1'b0;
    reg debug_disable_i = 1'b0;
    reg ue_i = 1'b0;
    reg wdog_i = 1'b0;
    reg [1:0] bad_core = 2'd0;
    reg [5:0] bad_grp = 6'd0;
    reg cmp_fault = 1'b0;
    reg rec_seen = 1'b0;
    reg [31:0] rdata;
    wire [5:0] mis;
    wire [31:0] avs_readdata_o;
    wire avs_waitrequest_o, fatal_reset_o, recover_reset_o, test_mode_o;
    wire [1:0] state_o;
    integer error_cnt = 0;
    integer total_checks = 0;
    rfm_manager #(.NUM_CMP(2), .WDOG_EXTERNAL(1), .WDOG_WIDTH(4), .MAGIC1(M1), .MAGIC2(M2)) rfm_manager_i (
        .clock_i(clock_i), .rst_i(rst_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hF),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .miscompare_i(mis),
        .tmr_disable_i(tmr_disable_i), .debug_disable_i(debug_disable_i), .bus_uncorrectable_error_in_i(ue_i),
        .watchdog_expired_i(wdog_i), .fatal_reset_o(fatal_reset_o), .recover_reset_o(recover_reset_o),
        .test_mode_o(test_mode_o), .lockstep_break_o(), .state_o(state_o));
    rfm_cores_model #(.NUM_CMP(2)) rfm_cores_model_i (.clock_i(clock_i), .rst_i(rst_i), .bad_core_i(bad_core),
        .bad_grp_i(bad_grp), .cmp_fault_i(cmp_fault), .miscompare_o(mis));
    always #20 clock_i = ~clock_i;
    always @(posedge clock_i) if (recover_reset_o === 1'b1) rec_seen <= 1'b1;
    // ==========================================
    // shared tasks
    task close_out;
        $display("errors %0d checks %0d", error_cnt, total_checks);
        if (error_cnt == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task chk(input [31:0] got, input [31:0] exp, input [8*12-1:0] msg);
        total_checks = total_checks + 1;
        if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("MISMATCH %0t %0s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task bus(input w, input [4:0] a, input [31:0] d);
        integer n;
        @(posedge clock_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= w;
        avs_read_i <= !w;
        n = 0;
        @(posedge clock_i);
        while (avs_waitrequest_o !== 1'b0 && n < 20) begin
            n = n + 1;
            @(posedge clock_i);
        end
        if (n == 20) begin
            error_cnt = error_cnt + 1;
            close_out;
        end
        rdata = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask
    task wait_st(input [1:0] s);
        integer n;
        n = 0;
        while (state_o !== s && n < 40) begin
            n = n + 1;
            @(negedge clock_i);
        end
        chk(state_o, s, "state");
    endtask
    task do_reset;
        rst_i <= 1'b1;
        {ue_i, wdog_i, debug_disable_i, cmp_fault, rec_seen} <= 5'h0;
        bad_core <= 2'd0;
        repeat (8) @(posedge clock_i);
        rst_i <= 1'b0;
    endtask
    // ==========================================
    // scenarios
    task t_regs;
        do_reset;
        bus(0, 5'h08, 0);
        chk(rdata, 32'hFFFFFFFF, "mask lo");
        bus(0, 5'h0C, 0);
        chk(rdata, 32'hFFFFFFFF, "mask hi");
        bus(1, 5'h0C, 32'h0000A5A5);
        bus(0, 5'h0C, 0);
        chk(rdata, 32'h0000A5A5, "mask wr");
        bus(1, 5'h10, 32'h0);
        bus(0, 5'h18, 0);
        chk(rdata, 32'h0, "unmapped");
        chk({fatal_reset_o, state_o}, 3'h0, "rst state");
    endtask
    task t_test;
        do_reset;
        bus(1, 5'h00, {7'h0, 1'b1, 6'h0, 2'h0, M2 ^ 8'h01, 8'h00});
        @(posedge clock_i);
        chk(test_mode_o, 1'b0, "bad magic2");
        bus(1, 5'h00, {7'h0, 1'b1, 6'h0, 2'h0, M2, 8'h00});
        @(posedge clock_i);
        chk(test_mode_o, 1'b1, "magic2");
    endtask
    task t_recover;
        do_reset;
        bad_grp <= 6'd1;
        bad_core <= 2'd2;
        wait_st(2'd1);
        bad_core <= 2'd0;
        bus(1, 5'h00, {14'h0, 2'h1, 8'h00, M1 ^ 8'h80});
        repeat (2) @(posedge clock_i);
        chk(rec_seen, 1'b0, "bad magic1");
        bus(1, 5'h00, {14'h0, 2'h1, 8'h00, M1});
        repeat (2) @(posedge clock_i);
        chk(rec_seen, 1'b1, "magic1");
    endtask
    task t_illegal;
        do_reset;
        bad_grp <= 6'd0;
        cmp_fault <= 1'b1;
        wait_st(2'd3);
        chk(fatal_reset_o, 1'b1, "fatal out");
        bus(0, 5'h04, 0);
        chk(rdata[1], 1'b1, "illegal st");
        cmp_fault <= 1'b0;
        debug_disable_i <= 1'b1;
        repeat (4) @(posedge clock_i);
        chk(fatal_reset_o, 1'b0, "dbg block");
        bus(1, 5'h00, {14'h0, 2'h2, 8'h00, M1});
        wait_st(2'd0);
    endtask
    task t_mask;
        do_reset;
        debug_disable_i <= 1'b1;
        bus(1, 5'h08, 32'hFFFFFFFE);
        bad_grp <= 6'd0;
        cmp_fault <= 1'b1;
        repeat (10) @(posedge clock_i);
        chk(state_o, 2'd0, "masked");
        bus(1, 5'h08, 32'hFFFFFFFF);
        wait_st(2'd3);
        chk(fatal_reset_o, 1'b0, "dbg fatal");
    endtask
    task t_fatal_in(input sel);
        do_reset;
        if (sel) wdog_i <= 1'b1;
        else ue_i <= 1'b1;
        wait_st(2'd3);
        bus(0, 5'h04, 0);
        chk(rdata[3:2], sel ? 2'h2 : 2'h1, "cause");
    endtask
    initial begin
        #2000000;
        error_cnt = error_cnt + 1;
        close_out;
    end
    initial begin
        t_regs;
        t_test;
        t_recover;
        t_illegal;
        t_mask;
        t_fatal_in(1'b0);
        t_fatal_in(1'b1);
        close_out;
    end
endmodule
